/* design/ttcrc_pkg.sv */
// Package with addresses, field positions, reset values and carrier types for the timer block.
package ttcrc_pkg;

   // Special-function register addresses.
   localparam logic [7:0] TTCRC_ADDR_CTRL = 8'hc8;
   localparam logic [7:0] TTCRC_ADDR_RELOAD_LOW = 8'hca;
   localparam logic [7:0] TTCRC_ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] TTCRC_ADDR_COUNT_LOW = 8'hcc;
   localparam logic [7:0] TTCRC_ADDR_COUNT_HIGH = 8'hcd;

   // Control register bit positions.
   localparam int TTCRC_BIT_HIGH_FLAG = 7;
   localparam int TTCRC_BIT_LOW_FLAG = 6;
   localparam int TTCRC_BIT_LOW_IRQ_EN = 5;
   localparam int TTCRC_BIT_CAPTURE_EN = 4;
   localparam int TTCRC_BIT_SPLIT = 3;
   localparam int TTCRC_BIT_RUN = 2;
   localparam int TTCRC_BIT_CAP_SOURCE = 1;
   localparam int TTCRC_BIT_EXT_CLOCK = 0;

   // Byte constants.
   localparam logic [7:0] TTCRC_BYTE_RESET = 8'h00;
   localparam logic [7:0] TTCRC_BYTE_ONES = 8'hff;
   localparam logic [7:0] TTCRC_BYTE_ONE = 8'h01;

   // Documented prescaler ratios.
   localparam int TTCRC_SYS_DIVIDE = 12;
   localparam int TTCRC_EXT_DIVIDE = 8;

   // Byte indices of the two counter halves.
   localparam int TTCRC_LOW = 0;
   localparam int TTCRC_HIGH = 1;

   // One register-port request from the core.
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } ttcrc_sfr_req_type;

   // Control register contents.
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_byte_irq_enable;
      logic lfo_capture_enable;
      logic split_mode_enable;
      logic run_control;
      logic capture_source_select;
      logic external_clock_select;
   } ttcrc_ctrl_type;

endpackage : ttcrc_pkg

/* design/ttcrc_timebase.sv */
// Prescaler producing system-divided and resynchronised external-divided count ticks.
`timescale 1ns/100ps
module ttcrc_timebase
   import ttcrc_pkg::*;
#(
   parameter int SYS_DIVIDE = TTCRC_SYS_DIVIDE,
   parameter int EXT_DIVIDE = TTCRC_EXT_DIVIDE
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ext_clk,
   output logic sys_div_tick,
   output logic ext_div_tick
);

   localparam int SW = $clog2(SYS_DIVIDE);
   localparam int EW = $clog2(EXT_DIVIDE);
   localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIVIDE - 1);
   localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIVIDE - 1);

   // Ratios below two would leave the counters with no width.
   initial begin
      if (SYS_DIVIDE < 2 || EXT_DIVIDE < 2) begin
         $error("ttcrc_timebase: divide ratios must be at least two.");
      end
   end

   logic [SW-1:0] sys_cnt_ff;
   logic [EW-1:0] ext_cnt_ff;
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic ext_prev_ff;
   logic ext_rise;

   // System divider; the tick marks the last cycle of each period.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sys_cnt_ff <= '0;
      end else if (sys_cnt_ff == SYS_LAST) begin
         sys_cnt_ff <= '0;
      end else begin
         sys_cnt_ff <= sys_cnt_ff + SW'(1);
      end
   end
   assign sys_div_tick = (sys_cnt_ff == SYS_LAST);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
      end else begin
         ext_meta_ff <= ext_clk;
         ext_sync_ff <= ext_meta_ff;
         ext_prev_ff <= ext_sync_ff;
      end
   end
   assign ext_rise = ext_sync_ff & ~ext_prev_ff;

   // Divides the synchronised external edges; the tick lasts one system cycle.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ext_cnt_ff <= '0;
      end else if (ext_rise) begin
         ext_cnt_ff <= (ext_cnt_ff == EXT_LAST) ? '0 : ext_cnt_ff + EW'(1);
      end
   end
   assign ext_div_tick = ext_rise && (ext_cnt_ff == EXT_LAST);

endmodule : ttcrc_timebase

/* design/ttcrc_timer.sv */
// Timer with split or 16-bit auto-reload, clock selection and oscillator edge capture.
//
// Function
// - Capture with interrupts enabled raises timer interrupt.
// - Capture copies 16-bit count into reload pair.
// - Split mode gives two auto-reloading 8-bit counters.
// - Sixteen-bit mode counts only while run set.
// - Split mode: run gates high byte only.
// - Capture source one selects oscillator falling edge.
// - External select picks system/12 or external/8.
// - External clock resynchronised before division.
// - Per-byte selects choose system or chosen timebase.
// - Reload low byte readable, writable, resets zero.
// - Sixteen-bit wrap reloads counter, sets high flag.
// - Overflow flags cleared only by software.
// - Per-byte select one means undivided system clock.
// - Low-byte overflow interrupts when low enable set.
`timescale 1ns/100ps
module ttcrc_timer
   import ttcrc_pkg::*;
#(
   parameter int SYS_DIVIDE = TTCRC_SYS_DIVIDE,
   parameter int EXT_DIVIDE = TTCRC_EXT_DIVIDE
) (
   input wire logic mclk,
   input wire logic rst_n,
   input ttcrc_sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic high_byte_clock_select,
   input wire logic low_byte_clock_select,
   input wire logic timer_irq_enable,
   input wire logic ext_clk,
   input wire logic lfo_clk,
   output logic timer_irq
);

   // True when the request writes the given address.
   function automatic logic sfr_hit(input ttcrc_sfr_req_type req, input logic [7:0] addr);
      sfr_hit = req.wr && (req.addr == addr);
   endfunction : sfr_hit

   ttcrc_ctrl_type ctrl_ff;
   ttcrc_ctrl_type wr_ctrl;
   logic [7:0] cnt_ff [2];
   logic [7:0] reload_ff [2];
   logic [7:0] sfr_rdata_ff;
   logic lfo_meta_ff;
   logic lfo_sync_ff;
   logic lfo_prev_ff;
   logic lfo_fall;
   logic cap_event;
   logic sys_div_tick;
   logic ext_div_tick;
   logic timebase_tick;
   logic [1:0] byte_sel;
   logic [1:0] byte_tick;
   logic [1:0] cnt_wr;
   logic [1:0] rl_wr;
   logic [1:0] byte_adv;
   logic [1:0] byte_wrap;
   logic wide_adv;
   logic wide_wrap;
   logic ctrl_wr;

   ttcrc_timebase #(
      .SYS_DIVIDE(SYS_DIVIDE),
      .EXT_DIVIDE(EXT_DIVIDE)
   ) u_timebase (
      .mclk(mclk),
      .rst_n(rst_n),
      .ext_clk(ext_clk),
      .sys_div_tick(sys_div_tick),
      .ext_div_tick(ext_div_tick)
   );

   assign timebase_tick = ctrl_ff.external_clock_select ? ext_div_tick : sys_div_tick;
   assign byte_sel = {high_byte_clock_select, low_byte_clock_select};
   assign cnt_wr = {sfr_hit(sfr_req, TTCRC_ADDR_COUNT_HIGH), sfr_hit(sfr_req, TTCRC_ADDR_COUNT_LOW)};
   assign rl_wr = {sfr_hit(sfr_req, TTCRC_ADDR_RELOAD_HIGH), sfr_hit(sfr_req, TTCRC_ADDR_RELOAD_LOW)};
   assign ctrl_wr = sfr_hit(sfr_req, TTCRC_ADDR_CTRL);
   assign wr_ctrl = ttcrc_ctrl_type'(sfr_req.wdata);

   // Per-byte tick selection, one copy for each counter byte.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_byte_clk
         assign byte_tick[gi] = byte_sel[gi] ? 1'b1 : timebase_tick;
      end
   endgenerate

   assign wide_adv = !ctrl_ff.split_mode_enable && ctrl_ff.run_control && byte_tick[TTCRC_LOW];
   assign wide_wrap = wide_adv && (cnt_ff[TTCRC_HIGH] == TTCRC_BYTE_ONES)
                      && (cnt_ff[TTCRC_LOW] == TTCRC_BYTE_ONES);
   // low byte free-running in split mode.
   assign byte_adv[TTCRC_LOW] = ctrl_ff.split_mode_enable ? byte_tick[TTCRC_LOW] : wide_adv;
   assign byte_adv[TTCRC_HIGH] = ctrl_ff.split_mode_enable
                                 ? (ctrl_ff.run_control && byte_tick[TTCRC_HIGH])
                                 : (wide_adv && cnt_ff[TTCRC_LOW] == TTCRC_BYTE_ONES);
   assign byte_wrap[TTCRC_LOW] = byte_adv[TTCRC_LOW] && (cnt_ff[TTCRC_LOW] == TTCRC_BYTE_ONES);
   assign byte_wrap[TTCRC_HIGH] = byte_adv[TTCRC_HIGH] && (cnt_ff[TTCRC_HIGH] == TTCRC_BYTE_ONES);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lfo_meta_ff <= 1'b0;
         lfo_sync_ff <= 1'b0;
         lfo_prev_ff <= 1'b0;
      end else begin
         lfo_meta_ff <= lfo_clk;
         lfo_sync_ff <= lfo_meta_ff;
         lfo_prev_ff <= lfo_sync_ff;
      end
   end
   assign lfo_fall = lfo_prev_ff & ~lfo_sync_ff;

   assign cap_event = lfo_fall && ctrl_ff.lfo_capture_enable && ctrl_ff.capture_source_select;

   // Counter bytes; a software write wins over counting in the same cycle.
   generate
      for (gi = 0; gi < 2; gi++) begin : g_counter
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               cnt_ff[gi] <= TTCRC_BYTE_RESET;
            end else if (cnt_wr[gi]) begin
               cnt_ff[gi] <= sfr_req.wdata;
            end else if (!ctrl_ff.split_mode_enable && wide_wrap) begin
               cnt_ff[gi] <= reload_ff[gi];
            end else if (ctrl_ff.split_mode_enable && byte_wrap[gi]) begin
               cnt_ff[gi] <= reload_ff[gi];
            end else if (byte_adv[gi]) begin
               cnt_ff[gi] <= cnt_ff[gi] + TTCRC_BYTE_ONE;
            end
         end
      end
   endgenerate

   // Reload bytes; a capture wins over a software write in the same cycle.
   generate
      for (gi = 0; gi < 2; gi++) begin : g_reload
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               reload_ff[gi] <= TTCRC_BYTE_RESET;
            end else if (cap_event) begin
               reload_ff[gi] <= cnt_ff[gi];
            end else if (rl_wr[gi]) begin
               reload_ff[gi] <= sfr_req.wdata;
            end
         end
      end
   endgenerate

   // Control register; hardware setting of a flag wins over a software clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_ff <= '0;
      end else begin
         if (ctrl_wr) begin
            ctrl_ff <= wr_ctrl;
         end
         if (byte_wrap[TTCRC_HIGH] || cap_event) begin
            ctrl_ff.high_overflow_flag <= 1'b1;
         end
         if (byte_wrap[TTCRC_LOW]) begin
            ctrl_ff.low_overflow_flag <= 1'b1;
         end
      end
   end

   // Read data, registered; unmapped addresses read zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sfr_rdata_ff <= TTCRC_BYTE_RESET;
      end else begin
         case (sfr_req.addr)
            TTCRC_ADDR_CTRL: sfr_rdata_ff <= ctrl_ff;
            TTCRC_ADDR_RELOAD_LOW: sfr_rdata_ff <= reload_ff[TTCRC_LOW];
            TTCRC_ADDR_RELOAD_HIGH: sfr_rdata_ff <= reload_ff[TTCRC_HIGH];
            TTCRC_ADDR_COUNT_LOW: sfr_rdata_ff <= cnt_ff[TTCRC_LOW];
            TTCRC_ADDR_COUNT_HIGH: sfr_rdata_ff <= cnt_ff[TTCRC_HIGH];
            default: sfr_rdata_ff <= TTCRC_BYTE_RESET;
         endcase
      end
   end
   assign sfr_rdata = sfr_rdata_ff;

   assign timer_irq = timer_irq_enable && (ctrl_ff.high_overflow_flag
                      || (ctrl_ff.low_byte_irq_enable && ctrl_ff.low_overflow_flag));

   // Checks of the counting, capture and flag behaviour.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_capture;
      cap_event && !ctrl_wr;
   endsequence

   sequence seq_flag_seen;
      ctrl_ff.high_overflow_flag ##0 (timer_irq || !timer_irq_enable);
   endsequence

   a_capture_irq: assert property (seq_capture ##1 timer_irq_enable |-> seq_flag_seen ##0 timer_irq)
      else $error("Capture did not raise the timer interrupt.");

   a_capture_copy: assert property (cap_event |=> reload_ff[TTCRC_HIGH] == $past(cnt_ff[TTCRC_HIGH])
                                    && reload_ff[TTCRC_LOW] == $past(cnt_ff[TTCRC_LOW]))
      else $error("Capture did not copy the count.");

   a_split_reload: assert property (ctrl_ff.split_mode_enable && byte_wrap[TTCRC_HIGH]
                                    && !cnt_wr[TTCRC_HIGH] |=> cnt_ff[TTCRC_HIGH]
                                    == $past(reload_ff[TTCRC_HIGH]))
      else $error("Split high byte did not reload.");

   a_run_gate: assert property (!ctrl_ff.split_mode_enable && !ctrl_ff.run_control && cnt_wr == 2'h0
                                |=> $stable(cnt_ff[TTCRC_LOW]) && $stable(cnt_ff[TTCRC_HIGH]))
      else $error("Counter moved while stopped.");

   a_split_free: assert property (ctrl_ff.split_mode_enable && low_byte_clock_select && !cnt_wr[TTCRC_LOW]
                                  && cnt_ff[TTCRC_LOW] != TTCRC_BYTE_ONES
                                  |=> cnt_ff[TTCRC_LOW] == $past(cnt_ff[TTCRC_LOW]) + TTCRC_BYTE_ONE)
      else $error("Split low byte did not count.");

   a_source_gate: assert property (!ctrl_ff.capture_source_select |-> !cap_event)
      else $error("Capture taken from the reserved source.");

   a_timebase_pick: assert property (!low_byte_clock_select |-> byte_tick[TTCRC_LOW]
                                     == (ctrl_ff.external_clock_select ? ext_div_tick : sys_div_tick))
      else $error("Wrong timebase for the low byte.");

   a_wide_wrap: assert property (wide_wrap && cnt_wr == 2'h0 |=> ctrl_ff.high_overflow_flag
                                 && cnt_ff[TTCRC_LOW] == $past(reload_ff[TTCRC_LOW])
                                 && cnt_ff[TTCRC_HIGH] == $past(reload_ff[TTCRC_HIGH]))
      else $error("Sixteen-bit wrap did not reload.");

   a_flag_sticky: assert property (ctrl_ff.low_overflow_flag && !ctrl_wr |=> ctrl_ff.low_overflow_flag)
      else $error("Low flag cleared without software.");

   a_sys_select: assert property (high_byte_clock_select |-> byte_tick[TTCRC_HIGH])
      else $error("High byte not on system clock.");

   a_low_irq: assert property (timer_irq_enable && ctrl_ff.low_byte_irq_enable
                               && ctrl_ff.low_overflow_flag |-> timer_irq)
      else $error("Low overflow interrupt missing.");

   a_edge_once: assert property (lfo_fall |=> !lfo_fall)
      else $error("Oscillator edge seen twice.");

   // Flags, reload writes, tick widths and interrupt masking.
   a_high_sticky: assert property (ctrl_ff.high_overflow_flag && !ctrl_wr |=> ctrl_ff.high_overflow_flag)
      else $error("High flag cleared without software.");

   a_low_flag_set: assert property (byte_wrap[TTCRC_LOW] |=> ctrl_ff.low_overflow_flag)
      else $error("Low byte wrap did not set the low flag.");

   a_split_low_reload: assert property (ctrl_ff.split_mode_enable && byte_wrap[TTCRC_LOW] && !cnt_wr[TTCRC_LOW]
                                        |=> cnt_ff[TTCRC_LOW] == $past(reload_ff[TTCRC_LOW]))
      else $error("Split low byte did not reload.");

   a_split_high_hold: assert property (ctrl_ff.split_mode_enable && !ctrl_ff.run_control && !cnt_wr[TTCRC_HIGH]
                                       |=> $stable(cnt_ff[TTCRC_HIGH]))
      else $error("Split high byte moved while stopped.");

   a_wide_step: assert property (!ctrl_ff.split_mode_enable && ctrl_ff.run_control && low_byte_clock_select
                                 && cnt_wr == 2'h0 && cnt_ff[TTCRC_LOW] != TTCRC_BYTE_ONES
                                 |=> cnt_ff[TTCRC_LOW] == $past(cnt_ff[TTCRC_LOW]) + TTCRC_BYTE_ONE
                                 && $stable(cnt_ff[TTCRC_HIGH]))
      else $error("Sixteen-bit count did not step.");

   a_reload_write: assert property (rl_wr[TTCRC_LOW] && !cap_event
                                    |=> reload_ff[TTCRC_LOW] == $past(sfr_req.wdata))
      else $error("Reload low write lost.");

   a_ext_tick_single: assert property (ext_div_tick |=> !ext_div_tick)
      else $error("External tick lasted more than one cycle.");

   a_sys_tick_single: assert property (sys_div_tick |=> !sys_div_tick)
      else $error("System tick lasted more than one cycle.");

   a_high_irq: assert property (timer_irq_enable && ctrl_ff.high_overflow_flag |-> timer_irq)
      else $error("High flag did not raise the interrupt.");

   a_irq_masked: assert property (!timer_irq_enable |-> !timer_irq)
      else $error("Interrupt raised while masked.");

   a_low_sys_select: assert property (low_byte_clock_select |-> byte_tick[TTCRC_LOW])
      else $error("Low byte not on system clock.");

endmodule : ttcrc_timer

/* verification/ttcrc_timer_tb.sv */
// Self-checking testbench for the timer with capture, reload and clock selection.
`timescale 1ns/100ps
module ttcrc_timer_tb
   import ttcrc_pkg::*;
   ;
   logic mclk;
   logic rst_n;
   ttcrc_sfr_req_type sfr_req;
   logic [7:0] sfr_rdata;
   logic high_byte_clock_select;
   logic low_byte_clock_select;
   logic timer_irq_enable;
   logic ext_clk;
   logic lfo_clk;
   logic timer_irq;
   int n_errors;
   int num_checks;

   // Device under test with the documented prescaler ratios.
   ttcrc_timer #(
      .SYS_DIVIDE(TTCRC_SYS_DIVIDE),
      .EXT_DIVIDE(TTCRC_EXT_DIVIDE)
   ) dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .high_byte_clock_select(high_byte_clock_select),
      .low_byte_clock_select(low_byte_clock_select),
      .timer_irq_enable(timer_irq_enable),
      .ext_clk(ext_clk),
      .lfo_clk(lfo_clk),
      .timer_irq(timer_irq)
   );

   // Free-running 250 MHz system clock.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Lets a number of falling edges pass with the write strobe low.
   task automatic idle(input int n);
      sfr_req.wr = 1'b0;
      repeat (n) @(negedge mclk);
   endtask : idle

   // Register write at a falling edge; wr stays high into a following write, and idle or a read lowers it.
   task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
      sfr_req.addr = addr;
      sfr_req.wr = 1'b1;
      sfr_req.wdata = data;
      @(posedge mclk);
      @(negedge mclk);
   endtask : sfr_write

   // Register read; the data is registered, so it is taken after the sampling edge.
   task automatic expect_reg(input string what, input logic [7:0] addr, input logic [7:0] exp);
      sfr_req.addr = addr;
      sfr_req.wr = 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      check(what, sfr_rdata, exp);
   endtask : expect_reg

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   // Watchdog that cuts a hang short well after the tests should have finished.
   initial begin
      #20000;
      n_errors++;
      $display("Error watchdog expected finish seen hang");
      conclude();
   end

   // Main sequence; count windows span the edges after one control write up to and including the next.
   initial begin
      n_errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      sfr_req = '0;
      high_byte_clock_select = 1'b0;
      low_byte_clock_select = 1'b1;
      timer_irq_enable = 1'b1;
      ext_clk = 1'b0;
      lfo_clk = 1'b1;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      idle(1);
      expect_reg("reload low reset", TTCRC_ADDR_RELOAD_LOW, 8'h00);
      expect_reg("control reset", TTCRC_ADDR_CTRL, 8'h00);
      check("irq reset", {7'h00, timer_irq}, 8'h00);
      sfr_write(TTCRC_ADDR_RELOAD_LOW, 8'ha5);
      expect_reg("reload low rw", TTCRC_ADDR_RELOAD_LOW, 8'ha5);
      sfr_write(8'hc9, 8'h3c);
      expect_reg("unmapped read", 8'hc9, 8'h00);
      expect_reg("reload low kept", TTCRC_ADDR_RELOAD_LOW, 8'ha5);
      // Sixteen-bit wrap from 0xfff8 with eleven system-clock counts.
      sfr_write(TTCRC_ADDR_RELOAD_LOW, 8'h34);
      sfr_write(TTCRC_ADDR_RELOAD_HIGH, 8'h12);
      sfr_write(TTCRC_ADDR_COUNT_LOW, 8'hf8);
      sfr_write(TTCRC_ADDR_COUNT_HIGH, 8'hff);
      sfr_write(TTCRC_ADDR_CTRL, 8'h04);
      idle(10);
      sfr_write(TTCRC_ADDR_CTRL, 8'hc0);
      expect_reg("wrap count low", TTCRC_ADDR_COUNT_LOW, 8'h37);
      expect_reg("wrap count high", TTCRC_ADDR_COUNT_HIGH, 8'h12);
      expect_reg("wrap flags", TTCRC_ADDR_CTRL, 8'hc0);
      check("irq on wrap", {7'h00, timer_irq}, 8'h01);
      idle(20);
      expect_reg("flags held", TTCRC_ADDR_CTRL, 8'hc0);
      expect_reg("stopped count", TTCRC_ADDR_COUNT_LOW, 8'h37);
      sfr_write(TTCRC_ADDR_CTRL, 8'h00);
      check("irq after clear", {7'h00, timer_irq}, 8'h00);
      // Split mode with run clear: only the low byte counts.
      sfr_write(TTCRC_ADDR_RELOAD_LOW, 8'h80);
      sfr_write(TTCRC_ADDR_RELOAD_HIGH, 8'h40);
      sfr_write(TTCRC_ADDR_COUNT_LOW, 8'hfe);
      sfr_write(TTCRC_ADDR_COUNT_HIGH, 8'h10);
      sfr_write(TTCRC_ADDR_CTRL, 8'h08);
      idle(10);
      sfr_write(TTCRC_ADDR_CTRL, 8'h40);
      expect_reg("split low", TTCRC_ADDR_COUNT_LOW, 8'h89);
      expect_reg("split high idle", TTCRC_ADDR_COUNT_HIGH, 8'h10);
      expect_reg("split low flag", TTCRC_ADDR_CTRL, 8'h40);
      check("irq low masked", {7'h00, timer_irq}, 8'h00);
      sfr_write(TTCRC_ADDR_CTRL, 8'h60);
      check("irq low enabled", {7'h00, timer_irq}, 8'h01);
      timer_irq_enable = 1'b0;
      idle(1);
      check("irq global off", {7'h00, timer_irq}, 8'h00);
      timer_irq_enable = 1'b1;
      // Split mode with run set: both bytes count and the high byte reloads.
      high_byte_clock_select = 1'b1;
      sfr_write(TTCRC_ADDR_COUNT_LOW, 8'h00);
      sfr_write(TTCRC_ADDR_COUNT_HIGH, 8'hfd);
      sfr_write(TTCRC_ADDR_CTRL, 8'h0c);
      idle(10);
      sfr_write(TTCRC_ADDR_CTRL, 8'h80);
      expect_reg("split run low", TTCRC_ADDR_COUNT_LOW, 8'h0b);
      expect_reg("split run high", TTCRC_ADDR_COUNT_HIGH, 8'h48);
      expect_reg("split high flag", TTCRC_ADDR_CTRL, 8'h80);
      // System clock divided by twelve over a 120-edge window.
      high_byte_clock_select = 1'b0;
      low_byte_clock_select = 1'b0;
      sfr_write(TTCRC_ADDR_COUNT_LOW, 8'h00);
      sfr_write(TTCRC_ADDR_COUNT_HIGH, 8'h00);
      sfr_write(TTCRC_ADDR_CTRL, 8'h04);
      idle(119);
      sfr_write(TTCRC_ADDR_CTRL, 8'h00);
      expect_reg("div12 low", TTCRC_ADDR_COUNT_LOW, 8'h0a);
      expect_reg("div12 high", TTCRC_ADDR_COUNT_HIGH, 8'h00);
      // External clock over 24 rising edges; high byte on system clock in split mode.
      high_byte_clock_select = 1'b1;
      sfr_write(TTCRC_ADDR_CTRL, 8'h0d);
      repeat (24) begin
         ext_clk = 1'b1;
         idle(3);
         ext_clk = 1'b0;
         idle(3);
      end
      idle(6);
      sfr_write(TTCRC_ADDR_CTRL, 8'h01);
      expect_reg("ext div8 low", TTCRC_ADDR_COUNT_LOW, 8'h0d);
      expect_reg("per byte high", TTCRC_ADDR_COUNT_HIGH, 8'h97);
      // Capture on a falling oscillator edge with the counter stopped.
      sfr_write(TTCRC_ADDR_COUNT_LOW, 8'hef);
      sfr_write(TTCRC_ADDR_COUNT_HIGH, 8'hbe);
      sfr_write(TTCRC_ADDR_CTRL, 8'h12);
      lfo_clk = 1'b0;
      idle(8);
      expect_reg("capture low", TTCRC_ADDR_RELOAD_LOW, 8'hef);
      expect_reg("capture high", TTCRC_ADDR_RELOAD_HIGH, 8'hbe);
      expect_reg("capture flag", TTCRC_ADDR_CTRL, 8'h92);
      check("irq on capture", {7'h00, timer_irq}, 8'h01);
      sfr_write(TTCRC_ADDR_CTRL, 8'h12);
      idle(10);
      expect_reg("single capture", TTCRC_ADDR_CTRL, 8'h12);
      lfo_clk = 1'b1;
      idle(8);
      expect_reg("rising ignored", TTCRC_ADDR_CTRL, 8'h12);
      // Capture disabled: an oscillator edge must not capture.
      // source stays one.
      sfr_write(TTCRC_ADDR_CTRL, 8'h02);
      sfr_write(TTCRC_ADDR_COUNT_LOW, 8'h11);
      lfo_clk = 1'b0;
      idle(8);
      expect_reg("capture off", TTCRC_ADDR_RELOAD_LOW, 8'hef);
      expect_reg("capture off flag", TTCRC_ADDR_CTRL, 8'h02);
      conclude();
   end

endmodule : ttcrc_timer_tb
